// *** audio_rx_pkg.sv ***
// constants, types and encodings of the stereo audio serial receiver
// assumes: shared by the receiver top and its helpers; no process lives here
//
// Behaviour
// [RQ1] samples arrive one bit at a time on the single serial data pin and are gathered into words
// [RQ2] 16, 20 and 24 bit words are accepted in the i2s, left-justified and right-justified framings
// [RQ3] the bit clock runs at 32, 48 or 64 times the sample rate and all three are handled
// [RQ4] in i2s framing a low frame clock marks the left slot and a high one the right slot
// [RQ5] in i2s framing the msb follows the frame clock change by one bit clock period
// [RQ6] every framing sends msb first and each bit is taken on the rising bit clock edge
// [RQ7] in i2s and left-justified framing the bits after the configured word length are ignored
// [RQ8] in left- and right-justified framing a high frame clock marks left and a low one right
// [RQ9] in left-justified framing the msb arrives in the same bit period as the frame clock change
// [RQ10] in right-justified framing with 24 bit words the first bit comes eight periods after the change
// [RQ11] in right-justified framing the lsb is in the last bit period before the frame clock changes
// [RQ12] in right-justified framing the unused leading bits of each slot are thrown away
// [RQ13] samples are two's complement and keep their sign in the parallel word
// [RQ14] the sender runs the frame clock at exactly one period per sample
// [RQ15] framing and word length come from static inputs and each left/right pair gets a one-cycle strobe; here a pair dropped on overrun gets none
// [RQ16] shorter samples sit at the top of the 24 bit word with the low bits cleared

package audio_rx_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int SAMPLE_W = 24;
    localparam int CNT_W = 6;
    localparam int FMT_W = 2;
    localparam int WLS_W = 2;
    localparam int CFG_W = FMT_W + WLS_W;
    localparam int PAIR_W = 2 * SAMPLE_W;
    localparam int RATIO_W = 2;
    localparam int XFER_W = PAIR_W + RATIO_W + 1;
    localparam int BUF_DEPTH = 2;

    // ----------------------------------------
    // encodings
    // ----------------------------------------
    typedef enum logic [FMT_W-1:0] {
        FMT_I2S = 2'h0,
        FMT_LEFT_JUST = 2'h1,
        FMT_RIGHT_JUST = 2'h2
    } format_t;

    typedef enum logic [WLS_W-1:0] {
        WL_16 = 2'h0,
        WL_20 = 2'h1,
        WL_24 = 2'h2
    } word_len_t;

    typedef enum logic [RATIO_W-1:0] {
        RATIO_NONE = 2'h0,
        RATIO_32 = 2'h1,
        RATIO_48 = 2'h2,
        RATIO_64 = 2'h3
    } ratio_t;

    // gray path: empty -> full -> back to empty
    typedef enum logic [0:0] {
        PEND_EMPTY = 1'h0,
        PEND_FULL = 1'h1
    } pend_state_t;

    // ----------------------------------------
    // counts and levels
    // ----------------------------------------
    localparam logic [CNT_W-1:0] BITS_16 = 6'h10;
    localparam logic [CNT_W-1:0] BITS_20 = 6'h14;
    localparam logic [CNT_W-1:0] BITS_24 = 6'h18;
    localparam logic [CNT_W-1:0] SLOT_32FS = 6'h10;
    localparam logic [CNT_W-1:0] SLOT_48FS = 6'h18;
    localparam logic [CNT_W-1:0] SLOT_64FS = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam logic FRAME_LEFT_I2S = 1'b0;
    localparam logic FRAME_LEFT_JUST = 1'b1;

endpackage

// *** toggle_sync.sv ***
// event crossing: a toggle from the link domain becomes a one-cycle pulse
// assumes: toggles are spaced far apart compared with four destination clocks
`timescale 1ns/10ps

module toggle_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic toggle_in,
    output logic event_pulse
);

    logic meta_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic seen_reg;

    // three stages; the change counts once the last two agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            meta_reg <= toggle_in;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                seen_reg <= sync3_reg;
            end
        end
    end

    assign event_pulse = (sync2_reg == sync3_reg) && (sync3_reg != seen_reg);

endmodule

// *** pair_buffer.sv ***
// small shift fifo; the head entry is a flop so output data come straight from a register
// assumes: single clock, valid/ready on both sides
`timescale 1ns/10ps

module pair_buffer #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;
    logic [CW-1:0] wr_idx;

    // full refuses a push even when a pop happens the same cycle
    assign in_ready = count_reg != CW'(DEPTH);
    assign out_valid = count_reg != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign wr_idx = count_reg - CW'(pop);
    assign out_data = mem_reg[0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

    // every entry but the top one shifts down on a pop; each takes the new word at the write slot
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                mem_reg[i] <= '0;
            end else if (push && (wr_idx == CW'(i))) begin
                mem_reg[i] <= in_data;
            end else if (pop && (i < DEPTH - 1)) begin
                mem_reg[i] <= mem_reg[(i < DEPTH - 1) ? i + 1 : i];
            end
        end
    end

endmodule

// *** stereo_audio_serial_receiver.sv ***
// stereo audio serial receiver: deserialiser on the bit clock, pair hand-off into the system clock
// assumes: the sender drives bit clock, frame clock and data; bit clock may stop between frames;
// framing and word length inputs are static while audio runs
`timescale 1ns/10ps

module stereo_audio_serial_receiver (
    input wire logic clk,
    input wire logic resetn,
    input wire logic audio_bit_clk,
    input wire logic audio_frame_clk,
    input wire logic audio_serial_in,
    input wire audio_rx_pkg::format_t format_sel,
    input wire audio_rx_pkg::word_len_t word_len_sel,
    output logic pair_valid,
    input wire logic pair_ready,
    output logic [audio_rx_pkg::SAMPLE_W-1:0] left_sample,
    output logic [audio_rx_pkg::SAMPLE_W-1:0] right_sample,
    output logic frame_strobe,
    output audio_rx_pkg::ratio_t bit_ratio,
    output logic ratio_error,
    output logic overrun
);
    import audio_rx_pkg::*;

    // ----------------------------------------
    // link domain: reset release
    // ----------------------------------------

    logic link_rst_meta_reg;
    logic link_rst_n_reg;

    // assertion is immediate, release waits for two bit clock edges
    always_ff @(posedge audio_bit_clk or negedge resetn) begin
        if (!resetn) begin
            link_rst_meta_reg <= 1'b0;
            link_rst_n_reg <= 1'b0;
        end else begin
            link_rst_meta_reg <= 1'b1;
            link_rst_n_reg <= link_rst_meta_reg;
        end
    end

    // ----------------------------------------
    // link domain: configuration crossing
    // ----------------------------------------

    logic [CFG_W-1:0] cfg_in;
    logic [CFG_W-1:0] cfg_meta_reg;
    logic [CFG_W-1:0] cfg_sync2_reg;
    logic [CFG_W-1:0] cfg_sync3_reg;
    logic [CFG_W-1:0] cfg_link_reg;

    assign cfg_in = {format_sel, word_len_sel};

    // per bit: three stages, the value moves on once the last two agree
    for (genvar i = 0; i < CFG_W; i++) begin : g_cfg_sync
        always_ff @(posedge audio_bit_clk or negedge resetn) begin
            if (!resetn) begin
                cfg_meta_reg[i] <= 1'b0;
                cfg_sync2_reg[i] <= 1'b0;
                cfg_sync3_reg[i] <= 1'b0;
                cfg_link_reg[i] <= 1'b0;
            end else begin
                cfg_meta_reg[i] <= cfg_in[i];
                cfg_sync2_reg[i] <= cfg_meta_reg[i];
                cfg_sync3_reg[i] <= cfg_sync2_reg[i];
                if (cfg_sync2_reg[i] == cfg_sync3_reg[i]) begin
                    cfg_link_reg[i] <= cfg_sync3_reg[i];
                end
            end
        end
    end

    format_t fmt_link;
    word_len_t wl_link;
    logic is_i2s;
    logic is_rj;
    logic [CNT_W-1:0] wl_bits;

    assign fmt_link = format_t'(cfg_link_reg[CFG_W-1 -: FMT_W]);
    assign wl_link = word_len_t'(cfg_link_reg[WLS_W-1:0]);
    assign is_i2s = fmt_link == FMT_I2S;
    assign is_rj = fmt_link == FMT_RIGHT_JUST;

    // word length in bits; an unused code falls back to the full width
    always_comb begin
        case (wl_link)
            WL_16: wl_bits = BITS_16; // RQ2
            WL_20: wl_bits = BITS_20; // RQ2
            WL_24: wl_bits = BITS_24; // RQ2
            default: wl_bits = BITS_24;
        endcase
    end

    // ----------------------------------------
    // link domain: slot boundaries
    // ----------------------------------------

    logic frame_d_reg;
    logic eff_prev_reg;
    logic eff_now;
    logic slot_edge;
    logic fin_left;

    // i2s looks at the frame clock one bit late, so the msb lines up with the boundary
    assign eff_now = is_i2s ? frame_d_reg : audio_frame_clk; // RQ5 RQ9
    assign slot_edge = eff_now != eff_prev_reg;

    // level of the slot just finished tells left from right
    assign fin_left = is_i2s ? (eff_prev_reg == FRAME_LEFT_I2S) // RQ4
                             : (eff_prev_reg == FRAME_LEFT_JUST); // RQ8

    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            frame_d_reg <= 1'b0;
            eff_prev_reg <= 1'b0;
        end else begin
            frame_d_reg <= audio_frame_clk; // RQ6
            eff_prev_reg <= eff_now;
        end
    end

    // ----------------------------------------
    // link domain: slot length and start-up
    // ----------------------------------------

    logic [CNT_W-1:0] slot_cnt_reg;
    logic started_reg;

    // slot_cnt_reg holds the bit count of the slot that ends at the next boundary
    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            slot_cnt_reg <= '0;
        end else if (slot_edge) begin
            slot_cnt_reg <= CNT_W'(1);
        end else if (slot_cnt_reg != CNT_MAX) begin
            slot_cnt_reg <= slot_cnt_reg + CNT_W'(1);
        end
    end

    // the slot in flight at reset release is partial, so nothing is kept before the first boundary
    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            started_reg <= 1'b0;
        end else if (slot_edge) begin
            started_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // link domain: shift register
    // ----------------------------------------

    logic [SAMPLE_W-1:0] shreg_reg;
    logic [CNT_W-1:0] cap_reg;
    logic take_bit;
    logic [SAMPLE_W-1:0] aligned;

    // right-justified keeps shifting so only the last bits before the boundary stay
    assign take_bit = is_rj || (cap_reg < wl_bits); // RQ7 RQ12

    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            shreg_reg <= '0;
            cap_reg <= '0;
        end else if (slot_edge) begin
            shreg_reg <= {{(SAMPLE_W-1){1'b0}}, audio_serial_in}; // RQ1 RQ9
            cap_reg <= CNT_W'(1);
        end else begin
            if (take_bit) begin
                shreg_reg <= {shreg_reg[SAMPLE_W-2:0], audio_serial_in}; // RQ1 RQ6
            end
            if (cap_reg < wl_bits) begin
                cap_reg <= cap_reg + CNT_W'(1); // RQ10 RQ11
            end
        end
    end

    // msb-align the captured bits; leading bits fall off the top and the low end fills with zero
    assign aligned = shreg_reg << (BITS_24 - cap_reg); // RQ13 RQ16

    // ----------------------------------------
    // link domain: frame assembly
    // ----------------------------------------

    logic [SAMPLE_W-1:0] left_hold_reg;
    logic left_ok_reg;
    logic [CNT_W-1:0] left_len_reg;
    logic [XFER_W-1:0] xfer_data_reg;
    logic xfer_tog_reg;
    ratio_t slot_ratio;
    logic len_bad;
    logic keep_slot;

    assign keep_slot = slot_edge && started_reg;

    // only the three documented slot lengths are accepted
    always_comb begin
        case (slot_cnt_reg)
            SLOT_32FS: slot_ratio = RATIO_32; // RQ3
            SLOT_48FS: slot_ratio = RATIO_48; // RQ3
            SLOT_64FS: slot_ratio = RATIO_64; // RQ3
            default: slot_ratio = RATIO_NONE;
        endcase
    end

    // both halves of a frame must match, since the frame clock is one period per sample
    assign len_bad = (slot_ratio == RATIO_NONE) || (slot_cnt_reg != left_len_reg); // RQ14

    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            left_hold_reg <= '0;
            left_ok_reg <= 1'b0;
            left_len_reg <= '0;
        end else if (keep_slot && fin_left) begin
            left_hold_reg <= aligned;
            left_ok_reg <= 1'b1;
            left_len_reg <= slot_cnt_reg;
        end else if (keep_slot) begin
            left_ok_reg <= 1'b0;
        end
    end

    // a right slot closes the pair; the data word is stable for a whole frame after the toggle
    always_ff @(posedge audio_bit_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            xfer_data_reg <= '0;
            xfer_tog_reg <= 1'b0;
        end else if (keep_slot && !fin_left && left_ok_reg) begin
            xfer_data_reg <= {len_bad, slot_ratio, left_hold_reg, aligned}; // RQ15
            xfer_tog_reg <= ~xfer_tog_reg;
        end
    end

    // ----------------------------------------
    // system domain: pair arrival
    // ----------------------------------------

    logic pair_event;

    toggle_sync u_pair_sync (
        .clk(clk),
        .resetn(resetn),
        .toggle_in(xfer_tog_reg),
        .event_pulse(pair_event)
    );

    // ----------------------------------------
    // system domain: pending stage
    // ----------------------------------------

    pend_state_t pend_state_reg;
    logic [PAIR_W-1:0] pend_data_reg;
    logic buf_in_valid;
    logic buf_in_ready;
    logic push;

    assign buf_in_valid = pend_state_reg == PEND_FULL;
    assign push = buf_in_valid && buf_in_ready;

    // the link cannot be stalled, so a pair waits here while the buffer is full
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_state_reg <= PEND_EMPTY;
        end else begin
            case (pend_state_reg)
                PEND_EMPTY: begin
                    if (pair_event) begin
                        pend_state_reg <= PEND_FULL;
                    end
                end
                PEND_FULL: begin
                    if (push && !pair_event) begin
                        pend_state_reg <= PEND_EMPTY;
                    end
                end
                default: pend_state_reg <= PEND_EMPTY;
            endcase
        end
    end

    // a new pair is taken whenever the slot is free or its old content leaves this cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_data_reg <= '0;
        end else if (pair_event && (!buf_in_valid || push)) begin
            pend_data_reg <= xfer_data_reg[PAIR_W-1:0];
        end
    end

    // ----------------------------------------
    // system domain: status
    // ----------------------------------------

    // a pair that finds both buffer and pending slot full is dropped and flagged until reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overrun <= 1'b0;
        end else if (pair_event && buf_in_valid && !push) begin
            overrun <= 1'b1;
        end
    end

    // ratio and its check follow the latest frame seen on the link
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_ratio <= RATIO_NONE;
            ratio_error <= 1'b0;
        end else if (pair_event) begin
            bit_ratio <= ratio_t'(xfer_data_reg[PAIR_W +: RATIO_W]); // RQ3
            ratio_error <= xfer_data_reg[XFER_W-1]; // RQ14
        end
    end

    // one pulse per stored pair, in the cycle after the pair is pushed into the buffer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_strobe <= 1'b0;
        end else begin
            frame_strobe <= push; // RQ15
        end
    end

    // ----------------------------------------
    // system domain: output buffer
    // ----------------------------------------

    logic [PAIR_W-1:0] out_pair;

    pair_buffer #(
        .WIDTH(PAIR_W),
        .DEPTH(BUF_DEPTH)
    ) u_pair_buffer (
        .clk(clk),
        .resetn(resetn),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(pend_data_reg),
        .out_valid(pair_valid),
        .out_ready(pair_ready),
        .out_data(out_pair)
    );

    // both halves come straight from the buffer head flops
    assign left_sample = out_pair[PAIR_W-1 -: SAMPLE_W];
    assign right_sample = out_pair[SAMPLE_W-1:0];

endmodule

// *** audio_rx_sva.sv ***
// checker for the stereo audio receiver output stream
// assumes: bound to the receiver top; every property runs on the system clock
`timescale 1ns/10ps

module audio_rx_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire audio_rx_pkg::word_len_t word_len_sel,
    input wire logic pair_valid,
    input wire logic pair_ready,
    input wire logic [audio_rx_pkg::SAMPLE_W-1:0] left_sample,
    input wire logic [audio_rx_pkg::SAMPLE_W-1:0] right_sample,
    input wire logic frame_strobe,
    input wire audio_rx_pkg::ratio_t bit_ratio,
    input wire logic ratio_error,
    input wire logic overrun
);
    import audio_rx_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_out_quiet;
        $rose(resetn) |-> !pair_valid && !frame_strobe && !overrun;
    endproperty
    a_out_quiet: assert property (p_out_quiet) else $error("outputs busy right after reset");

    property p_strobe_pulse;
        frame_strobe |=> !frame_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("pair strobe longer than one cycle");

    property p_strobe_cause;
        frame_strobe |-> pair_valid;
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("pair strobe with no pair stored");

    property p_entry_strobe;
        $rose(pair_valid) |-> frame_strobe;
    endproperty
    a_entry_strobe: assert property (p_entry_strobe) else $error("pair entered without strobe");

    property p_hold;
        pair_valid && !pair_ready |=> pair_valid && $stable(left_sample) && $stable(right_sample);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled pair changed or vanished");

    property p_pad_16;
        pair_valid && word_len_sel == WL_16 |-> left_sample[7:0] == 8'h00 && right_sample[7:0] == 8'h00;
    endproperty
    a_pad_16: assert property (p_pad_16) else $error("16 bit sample low byte not clear");

    property p_pad_20;
        pair_valid && word_len_sel == WL_20 |-> left_sample[3:0] == 4'h0 && right_sample[3:0] == 4'h0;
    endproperty
    a_pad_20: assert property (p_pad_20) else $error("20 bit sample low nibble not clear");

    property p_ratio_known;
        frame_strobe && !ratio_error |-> bit_ratio != RATIO_NONE;
    endproperty
    a_ratio_known: assert property (p_ratio_known) else $error("good frame with unknown ratio");

    property p_overrun_sticky;
        overrun |=> overrun [*3];
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag dropped");
endmodule

bind stereo_audio_serial_receiver audio_rx_sva i_sva (.clk(clk), .resetn(resetn),
    .word_len_sel(word_len_sel), .pair_valid(pair_valid), .pair_ready(pair_ready),
    .left_sample(left_sample), .right_sample(right_sample), .frame_strobe(frame_strobe),
    .bit_ratio(bit_ratio), .ratio_error(ratio_error), .overrun(overrun));

// *** audio_sender.sv ***
// model of the sending audio processor: bit clock, frame clock and serial data
// assumes: driven through its send task; bit clock stands still low between bursts
`timescale 1ns/10ps

module audio_sender (
    output logic bclk,
    output logic lrclk,
    output logic sdata
);
    import audio_rx_pkg::*;
    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        sdata = 1'b0;
    end

    // one bit: frame level and data move while the bit clock is low, taken at its rise
    task automatic put_bit(input logic lr, input logic d);
        lrclk = lr;
        sdata = d;
        #32;
        bclk = 1'b1;
        #32;
        bclk = 1'b0;
    endtask

    // position of a sample bit inside its slot; padding is junk so masking really matters
    function automatic logic slot_bit(input format_t f, input int wl, input int slot, input int p,
                                      input logic [23:0] w);
        int k;
        k = (f == FMT_I2S) ? p - 1 : (f == FMT_RIGHT_JUST) ? p - (slot - wl) : p;
        if (k < 0 || k >= wl) begin
            return 1'($urandom % 2);
        end
        return w[23 - k];
    endfunction

    // whole frames, left then right, plus a short tail that closes the last pair
    task automatic send(input format_t f, input int wl, input int slot, input int n,
                        input logic [23:0] lw [8], input logic [23:0] rw [8]);
        logic left_lvl;
        left_lvl = (f == FMT_I2S) ? FRAME_LEFT_I2S : FRAME_LEFT_JUST;
        for (int i = 0; i < n; i++) begin
            for (int p = 0; p < slot; p++) put_bit(left_lvl, slot_bit(f, wl, slot, p, lw[i]));
            for (int p = 0; p < slot; p++) put_bit(!left_lvl, slot_bit(f, wl, slot, p, rw[i]));
        end
        put_bit(left_lvl, 1'b0);
        put_bit(left_lvl, 1'b1);
        sdata = !sdata; // released line holds nothing trustworthy
    endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the stereo audio serial receiver
// assumes: audio_sender plays the far side; consumer stalls at random
`timescale 1ns/10ps

module testbench;
    import audio_rx_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pair_ready = 1'b0;
    logic ready_en = 1'b0;
    format_t fmt = FMT_I2S;
    word_len_t wls = WL_16;
    wire bclk, lrclk, sdata;
    logic pair_valid, frame_strobe, ratio_error, overrun;
    logic [SAMPLE_W-1:0] left_sample, right_sample;
    ratio_t bit_ratio;
    int n_errors = 0;
    int n_tests = 0;
    logic [47:0] rx_q [$];
    logic [23:0] lw [8];
    logic [23:0] rw [8];

    audio_sender i_src (.bclk(bclk), .lrclk(lrclk), .sdata(sdata));
    stereo_audio_serial_receiver i_dut (.clk(clk), .resetn(resetn), .audio_bit_clk(bclk),
        .audio_frame_clk(lrclk), .audio_serial_in(sdata), .format_sel(fmt), .word_len_sel(wls),
        .pair_valid(pair_valid), .pair_ready(pair_ready), .left_sample(left_sample),
        .right_sample(right_sample), .frame_strobe(frame_strobe), .bit_ratio(bit_ratio),
        .ratio_error(ratio_error), .overrun(overrun));

    initial begin
        forever #50 clk = ~clk;
    end

    // ------------------------------
    // consumer and monitor
    // ------------------------------
    always @(posedge clk) begin
        pair_ready <= ready_en & 1'($urandom % 2);
    end

    // the pair is read at the falling edge, where the buffer outputs have settled before the taking edge
    always @(negedge clk) begin
        if (resetn && pair_valid === 1'b1 && pair_ready === 1'b1) rx_q.push_back({left_sample, right_sample});
    end

    function automatic logic [23:0] exp_word(input logic [23:0] w, input int wl);
        return w & ~(24'hffffff >> wl);
    endfunction

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // config only changes while reset is held
    task automatic restart(input format_t f, input word_len_t w);
        resetn <= 1'b0;
        fmt <= f;
        wls <= w;
        repeat (20) @(posedge clk);
        rx_q.delete();
        resetn <= 1'b1;
    endtask

    task automatic drain();
        int i;
        repeat (10) @(posedge clk);
        for (i = 0; i < 400 && pair_valid !== 1'b0; i++) @(posedge clk);
        if (i == 400) begin
            n_errors++;
            results();
        end
    endtask

    // ------------------------------
    // every framing with every word length, then an overflow
    // ------------------------------
    initial begin
        int wl;
        int slot;
        int n;
        void'($urandom(32'h97be));
        ready_en <= 1'b1;
        for (int c = 0; c < 9; c++) begin
            restart(format_t'(c / 3), word_len_t'(c % 3));
            wl = 16 + 4 * (c % 3);
            slot = (wl == 16 && c >= 3) ? 16 : (wl == 24 ? 32 : 24 + 8 * int'($urandom % 2));
            for (int i = 0; i < 8; i++) begin
                lw[i] = 24'($urandom);
                rw[i] = 24'($urandom);
            end
            lw[3] = 24'h800000;
            rw[3] = 24'h7fffff;
            i_src.send(format_t'(c / 3), wl, slot, 5, lw, rw);
            drain();
            n = rx_q.size();
            check("pair count", 48'(n >= 3), 48'h1);
            for (int k = 1; k <= 3 && k <= n; k++)
                check("pair", rx_q[n - k], {exp_word(lw[5 - k], wl), exp_word(rw[5 - k], wl)});
            check("ratio", 48'(bit_ratio), 48'(slot == 16 ? RATIO_32 : slot == 24 ? RATIO_48 : RATIO_64));
            check("ratio error", 48'(ratio_error), 48'h0);
        end
        ready_en <= 1'b0;
        restart(FMT_LEFT_JUST, WL_24);
        i_src.send(FMT_LEFT_JUST, 24, 32, 8, lw, rw);
        repeat (20) @(posedge clk);
        check("overrun and valid", 48'({overrun, pair_valid}), 48'h3);
        ready_en <= 1'b1;
        drain();
        check("pairs kept", 48'(rx_q.size()), 48'h3);
        for (int k = 1; k < 3 && k < rx_q.size(); k++)
            check("kept pair", rx_q[k], {lw[k], rw[k]});
        check("overrun sticky", 48'(overrun), 48'h1);
        results();
    end
endmodule
